// [hw/btr_pkg.sv]
// Purpose: Shared constants and types for the balance, timer and recovery
//          command block.
// Assumes: 50 MHz system clock, APB with 32-bit data.
// Notes:   Offsets are byte addresses; each register takes one word.
package btr_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Bus geometry and register offsets
    localparam int          ADDR_W        = 8;
    localparam int          DATA_W        = 32;
    localparam logic [7:0]  ADDR_BALANCE  = 8'h00;
    localparam logic [7:0]  ADDR_TIMER    = 8'h04;
    localparam logic [7:0]  ADDR_RECOVERY = 8'h08;
    localparam logic [7:0]  ADDR_STATUS   = 8'h0C;

    ////////////////////////////////////////////////////////////////////////
    // Field layouts and reset values
    localparam logic [7:0]  BALANCE_VALID  = 8'h3E;
    localparam logic [7:0]  BALANCE_RST    = 8'h00;
    localparam logic [15:0] TIMER_WRITABLE = 16'h0FFF;
    localparam logic [15:0] TIMER_RST      = 16'h0000;
    localparam logic [7:0]  RECOVERY_VALID = 8'hFE;
    localparam int          TMR_VALUE_LSB  = 0;
    localparam int          TMR_SD_BIT     = 8;
    localparam int          TMR_DLY_LSB    = 9;
    localparam int          TMR_WAKE_BIT   = 11;
    localparam int          ST_RUNNING_BIT = 0;
    localparam int          ST_SHUT_BIT    = 1;
    localparam int          ST_REG_BIT     = 2;
    localparam int          ST_LONG_BIT    = 3;
    localparam int          ST_REMAIN_LSB  = 8;

    ////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int          CLK_HZ        = 50_000_000;
    localparam int          TICK_MS       = 250;
    localparam int          TICK_CYCLES   = CLK_HZ / 1000 * TICK_MS;
    localparam int          SEC_MS        = 1000;
    localparam logic [2:0]  TICKS_PER_SEC = 3'(SEC_MS / TICK_MS);
    localparam logic [7:0]  SHORT_MAX     = 8'h10;
    localparam logic [7:0]  LONG_OFFSET   = 8'h0C;
    localparam int          DLY1_MS       = 250;
    localparam int          DLY2_MS       = 1000;
    localparam int          DLY3_MS       = 4000;
    localparam logic [4:0]  DLY1_TICKS    = 5'(DLY1_MS / TICK_MS);
    localparam logic [4:0]  DLY2_TICKS    = 5'(DLY2_MS / TICK_MS);
    localparam logic [4:0]  DLY3_TICKS    = 5'(DLY3_MS / TICK_MS);

    ////////////////////////////////////////////////////////////////////////
    // Countdown states
    typedef enum logic [1:0] {
        TMR_IDLE,
        TMR_DELAY,
        TMR_SHUT,
        TMR_RUN
    } timer_state_e;

endpackage

// [hw/level_sync.sv]
// Purpose: Two-flop synchroniser for a vector of independent levels.
// Assumes: Each bit is a slow level; bits are not coherent as a word.
// Notes:   Stage one feeds stage two only.
module level_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             sys_clk,   // System clock
    input  wire logic             srst,      // Synchronous reset
    input  wire logic [WIDTH-1:0] async_in,  // Levels from outside
    output logic      [WIDTH-1:0] sync_out   // Synchronised levels
);

    logic [WIDTH-1:0] stage_one;

    // Two flip-flops per bit
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            stage_one <= '0;
            sync_out  <= '0;
        end
        else
        begin
            stage_one <= async_in;
            sync_out  <= stage_one;
        end
    end

endmodule

// [hw/quarter_tick.sv]
// Purpose: Free-running tick generator with restart.
// Assumes: CYCLES is at least 2.
// Notes:   Restart realigns so the first tick is a full period later.
module quarter_tick #(
    parameter int CYCLES = 12_500_000
) (
    input  wire logic sys_clk,  // System clock
    input  wire logic srst,     // Synchronous reset
    input  wire logic restart,  // Realign the period
    output logic      tick      // One-cycle pulse per period
);

    localparam int CW = $clog2(CYCLES);
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

    logic [CW-1:0] count;

    // Period counter
    always_ff @(posedge sys_clk)
    begin
        if (srst || restart)
        begin
            count <= '0;
            tick  <= 1'b0;
        end
        else if (count == LAST)
        begin
            count <= '0;
            tick  <= 1'b1;
        end
        else
        begin
            count <= count + 1'b1;
            tick  <= 1'b0;
        end
    end

endmodule

// [hw/balance_timer_recovery_cmds.sv]
// Purpose: Command registers for cell balancing, the regulator countdown
//          timer and protection recovery, reached over APB.
// Assumes: Alarm status bits arrive from another domain; the regulator
//          output setting comes from logic on this clock.
// Notes:   Zero-wait APB slave; read data is captured in the setup cycle.
//
// Notes on behaviour
// - Balance register reads back balancing cells
// - Set bits start balancing; zero stops all
// - Reserved balance bits 7,6,0 read zero
// - Bits 1..5 pick cells 1..5, lowest first
// - Alarm wake off: alarms never restore regulator
// - Alarm wake with shutdown: alarm restores regulator
// - Delay field picks 0, 250ms, 1s, 4s
// - Shutdown bit turns regulator off after delay
// - Expiry restores regulator per output setting
// - Value 1-16 quarter seconds, 17-255 seconds
// - Zero value disables the countdown
// - Every non-zero value write restarts countdown
// - Recovery bits 7..1 pick faults, 0 reserved
// - Writing one triggers recovery; zero does nothing
//
// The placing of the registers and the APB interface to the registers were left to the implementer.
module balance_timer_recovery_cmds
    import btr_pkg::*;
#(
    parameter int ALARM_W     = 16,                  // Alarm status width
    parameter int TICK_PERIOD = btr_pkg::TICK_CYCLES // Cycles per tick
) (
    input  wire logic                      sys_clk,          // 50 MHz clock
    input  wire logic                      srst,             // Sync reset
    input  wire logic                      psel,             // APB select
    input  wire logic                      penable,          // APB enable
    input  wire logic                      pwrite,           // APB write
    input  wire logic [btr_pkg::ADDR_W-1:0] paddr,           // APB address
    input  wire logic [btr_pkg::DATA_W-1:0] pwdata,          // APB wdata
    output logic      [btr_pkg::DATA_W-1:0] prdata,          // APB rdata
    output logic                           pready,           // APB ready
    output logic                           pslverr,          // APB error
    input  wire logic [ALARM_W-1:0]        alarm_status,     // Alarm bits
    input  wire logic                      regulator_output_config, // On
    output logic      [7:0]                balance_select_bits, // Cells
    output logic                           regulator_output, // LDO enable
    output logic      [7:0]                fault_recover_pulse // Recovery
);

    import btr_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    logic [7:0]         balance_cell_mask;
    logic [15:0]        wake_countdown_control;
    timer_state_e       timer_state;
    logic [7:0]         remaining;
    logic               long_mode;
    logic [2:0]         quarter;
    logic [4:0]         delay_left;

    // Alarm path and tick
    logic [ALARM_W-1:0] alarm_sync;
    logic [ALARM_W-1:0] alarm_prev;
    logic               alarm_rise;
    logic               tick;

    // Bus decode
    logic               setup_phase;
    logic               access_write;
    logic               hit_balance;
    logic               hit_timer;
    logic               hit_recovery;
    logic               hit_status;
    logic               hit_any;

    // Timer write and countdown
    logic [7:0]         new_value;
    logic               new_sd;
    logic [1:0]         new_dly;
    logic               timer_write;
    logic               timer_start;
    logic               timer_stop;
    logic [4:0]         start_delay;
    logic               unit_done;
    logic               expire;
    logic               wake_now;

    // Read path
    logic [DATA_W-1:0]  status_word;
    logic [DATA_W-1:0]  read_mux;

    ////////////////////////////////////////////////////////////////////////
    // Helpers
    // Alarms pass two flops
    level_sync #(
        .WIDTH    (ALARM_W)
    ) u_alarm_sync (
        .sys_clk  (sys_clk),
        .srst     (srst),
        .async_in (alarm_status),
        .sync_out (alarm_sync)
    );

    // Tick base, realigned on start
    quarter_tick #(
        .CYCLES   (TICK_PERIOD)
    ) u_tick (
        .sys_clk  (sys_clk),
        .srst     (srst),
        .restart  (timer_start),
        .tick     (tick)
    );

    ////////////////////////////////////////////////////////////////////////
    // APB decode
    assign setup_phase  = psel && !penable;
    assign access_write = psel && penable && pwrite;
    assign pready       = psel && penable;

    // Register decode
    assign hit_balance  = (paddr == ADDR_BALANCE);
    assign hit_timer    = (paddr == ADDR_TIMER);
    assign hit_recovery = (paddr == ADDR_RECOVERY);
    assign hit_status   = (paddr == ADDR_STATUS);
    assign hit_any      = hit_balance || hit_timer || hit_recovery
                          || hit_status;

    // Read data and error, captured in the setup cycle
    always_comb
    begin
        read_mux = '0;
        if (hit_balance)
            read_mux = DATA_W'(balance_cell_mask & BALANCE_VALID);
        else if (hit_timer)
            read_mux = DATA_W'(wake_countdown_control & TIMER_WRITABLE);
        else if (hit_status)
            read_mux = status_word;
    end

    // Registered read response
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            prdata  <= '0;
            pslverr <= 1'b0;
        end
        else if (setup_phase)
        begin
            prdata  <= pwrite ? '0 : read_mux;
            pslverr <= !hit_any || (pwrite && hit_status);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Balancing mask; reserved bits are dropped on write
    always_ff @(posedge sys_clk)
    begin
        if (srst)
            balance_cell_mask <= BALANCE_RST;
        else if (access_write && hit_balance)
            balance_cell_mask <= pwdata[7:0] & BALANCE_VALID;
    end

    // Bit n drives the switch of cell n, bit 1 being the lowest cell
    assign balance_select_bits = balance_cell_mask;

    ////////////////////////////////////////////////////////////////////////
    // Recovery triggers: one-cycle pulse per one written to bits 7..1
    generate
        for (genvar b = 0; b < 8; b++)
        begin : g_recover
            always_ff @(posedge sys_clk)
            begin
                if (srst)
                    fault_recover_pulse[b] <= 1'b0;
                else
                    fault_recover_pulse[b] <= access_write && hit_recovery
                        && pwdata[b] && RECOVERY_VALID[b];
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Timer control register
    assign timer_write = access_write && hit_timer;
    assign new_value   = pwdata[TMR_VALUE_LSB +: 8];
    assign new_sd      = pwdata[TMR_SD_BIT];
    assign new_dly     = pwdata[TMR_DLY_LSB +: 2];

    // Start and stop strobes
    assign timer_start = timer_write && (new_value != '0);
    assign timer_stop  = timer_write && (new_value == '0);

    // Stored control word
    always_ff @(posedge sys_clk)
    begin
        if (srst)
            wake_countdown_control <= TIMER_RST;
        else if (timer_write)
            wake_countdown_control <= pwdata[15:0] & TIMER_WRITABLE;
    end

    // Delay before shutdown in ticks
    always_comb
    begin
        case (new_dly)
            2'h1:    start_delay = DLY1_TICKS;
            2'h2:    start_delay = DLY2_TICKS;
            2'h3:    start_delay = DLY3_TICKS;
            default: start_delay = '0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Alarm rising edge on synchronised bits
    always_ff @(posedge sys_clk)
    begin
        if (srst)
            alarm_prev <= '0;
        else
            alarm_prev <= alarm_sync;
    end

    // Any bit going high
    assign alarm_rise = |(alarm_sync & ~alarm_prev);

    // Alarm wake needs both the wake and the shutdown bits
    assign wake_now = alarm_rise
                      && wake_countdown_control[TMR_WAKE_BIT]
                      && wake_countdown_control[TMR_SD_BIT]
                      && (timer_state == TMR_SHUT
                          || timer_state == TMR_DELAY);

    ////////////////////////////////////////////////////////////////////////
    // Countdown: short range counts ticks, long range counts seconds
    assign unit_done = tick && (!long_mode
                       || quarter == TICKS_PER_SEC - 3'h1);

    // Last unit of a running timer
    assign expire    = unit_done && (remaining == 8'h01)
                       && (timer_state != TMR_IDLE);

    // Units left and second phase
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            remaining <= '0;
            long_mode <= 1'b0;
            quarter   <= '0;
        end
        else if (timer_start)
        begin
            long_mode <= (new_value > SHORT_MAX);
            remaining <= (new_value > SHORT_MAX) ? new_value - LONG_OFFSET
                                                 : new_value;
            quarter   <= '0;
        end
        else if (timer_stop || expire)
        begin
            remaining <= '0;
            quarter   <= '0;
        end
        else if (timer_state != TMR_IDLE && tick)
        begin
            quarter <= (quarter == TICKS_PER_SEC - 3'h1) ? '0
                                                         : quarter + 3'h1;
            if (unit_done)
                remaining <= remaining - 8'h01;
        end
    end

    // Shutdown delay counter
    always_ff @(posedge sys_clk)
    begin
        if (srst)
            delay_left <= '0;
        else if (timer_start)
            delay_left <= start_delay;
        else if (timer_state == TMR_DELAY && tick && delay_left != '0)
            delay_left <= delay_left - 5'h01;
    end

    ////////////////////////////////////////////////////////////////////////
    // Timer state; a write outranks expiry, expiry outranks alarm wake
    always_ff @(posedge sys_clk)
    begin
        if (srst)
            timer_state <= TMR_IDLE;
        else if (timer_start)
        begin
            if (!new_sd)
                timer_state <= TMR_RUN;
            else if (!regulator_output || start_delay == '0)
                timer_state <= TMR_SHUT;
            else
                timer_state <= TMR_DELAY;
        end
        else if (timer_stop)
            timer_state <= TMR_IDLE;
        else if (expire)
            timer_state <= TMR_IDLE;
        else if (wake_now)
            timer_state <= TMR_RUN;
        else
        begin
            case (timer_state)
                TMR_DELAY:
                begin
                    if (tick && delay_left == 5'h01)
                        timer_state <= TMR_SHUT;
                end
                TMR_IDLE,
                TMR_SHUT,
                TMR_RUN:
                    timer_state <= timer_state;
                default:
                    timer_state <= TMR_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Regulator enable follows its setting unless the timer holds it off
    always_ff @(posedge sys_clk)
    begin
        if (srst)
            regulator_output <= 1'b0;
        else
            regulator_output <= regulator_output_config
                                && timer_state != TMR_SHUT;
    end

    ////////////////////////////////////////////////////////////////////////
    // Status word
    always_comb
    begin
        status_word                 = '0;
        status_word[ST_RUNNING_BIT] = (timer_state != TMR_IDLE);
        status_word[ST_SHUT_BIT]    = (timer_state == TMR_SHUT);
        status_word[ST_REG_BIT]     = regulator_output;
        status_word[ST_LONG_BIT]    = long_mode;
        status_word[ST_REMAIN_LSB +: 8] = remaining;
    end

endmodule

// [verification/btr_checker_assertions.sv]
// Purpose: Concurrent checks on the command block's ports.
// Assumes: One clock; synchronous active-high reset.
// Notes:   Attached by bind from the bench top file.
module btr_checker
    import btr_pkg::*;
(
    input wire logic                       sys_clk,   // Clock
    input wire logic                       srst,      // Reset
    input wire logic                       psel,      // Select
    input wire logic                       penable,   // Enable
    input wire logic                       pwrite,    // Direction
    input wire logic [btr_pkg::ADDR_W-1:0] paddr,     // Address
    input wire logic [btr_pkg::DATA_W-1:0] pwdata,    // Write data
    input wire logic [btr_pkg::DATA_W-1:0] prdata,    // Read data
    input wire logic                       regulator_output_config, // On
    input wire logic [7:0]                 balance_select_bits, // Cells
    input wire logic                       regulator_output,    // LDO
    input wire logic [7:0]                 fault_recover_pulse  // Pulses
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (srst);

    ////////////////////////////////////////////////////////////////////////
    // Decoded bus phases
    wire logic wr_bal = psel && penable && pwrite && paddr == ADDR_BALANCE;
    wire logic wr_rec = psel && penable && pwrite && paddr == ADDR_RECOVERY;
    wire logic rd_bal = psel && !penable && !pwrite && paddr == ADDR_BALANCE;

    ////////////////////////////////////////////////////////////////////////
    // Balance mask
    chk_balance_write:
        assert property (wr_bal |=> balance_select_bits ==
                         ($past(pwdata[7:0]) & BALANCE_VALID))
        else $error("balance mask differs from written value");
    chk_balance_hold:
        assert property (!wr_bal |=> $stable(balance_select_bits))
        else $error("balance mask changed without a write");
    chk_balance_read:
        assert property (rd_bal |=> prdata ==
                         {24'h0, $past(balance_select_bits)})
        else $error("balance read differs from active cells");
    chk_reserved_cells:
        assert property ((balance_select_bits & ~BALANCE_VALID) == 8'h00)
        else $error("reserved balance bit set");

    ////////////////////////////////////////////////////////////////////////
    // Recovery pulses and regulator
    chk_recover_pulse:
        assert property (wr_rec |=> fault_recover_pulse ==
                         ($past(pwdata[7:0]) & RECOVERY_VALID))
        else $error("recovery pulse differs from written bits");
    chk_recover_quiet:
        assert property (!wr_rec |=> fault_recover_pulse == 8'h00)
        else $error("recovery pulse without a write");
    chk_recover_bit0:
        assert property (fault_recover_pulse[0] == 1'b0)
        else $error("reserved recovery bit pulsed");
    chk_regulator_cfg:
        assert property (regulator_output |-> $past(regulator_output_config))
        else $error("regulator on while setting was off");

    cover property (wr_bal ##1 balance_select_bits == 8'h00);
    cover property (fault_recover_pulse != 8'h00);
    cover property ($fell(regulator_output));
endmodule

// [verification/apb_host.sv]
// Purpose: Host model issuing register commands over APB.
// Assumes: Slave may insert any number of wait states.
// Notes:   Released address and data show inverted values.
module apb_host
    import btr_pkg::*;
(
    input  wire logic                       sys_clk, // Clock
    input  wire logic                       pready,  // Slave ready
    input  wire logic [btr_pkg::DATA_W-1:0] prdata,  // Read data
    input  wire logic                       pslverr, // Slave error
    output logic                            psel,    // Select
    output logic                            penable, // Enable
    output logic                            pwrite,  // Direction
    output logic      [btr_pkg::ADDR_W-1:0] paddr,   // Address
    output logic      [btr_pkg::DATA_W-1:0] pwdata   // Write data
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle bus at time zero
    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
    end

    ////////////////////////////////////////////////////////////////////////
    // One transfer: setup, then access held until pready is sampled high
    task automatic xfer(input logic wr, input logic [7:0] a,
                        input logic [31:0] d,
                        output logic [31:0] q, output logic err);
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do
        begin
            @(posedge sys_clk);
        end
        while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~d;
    endtask
endmodule

// [verification/balance_timer_recovery_cmds_tb.sv]
// Purpose: Self-checking bench for the balance, timer and recovery block.
// Assumes: Tick shortened to T cycles; host model drives the bus.
// Notes:   Random data comes from a fixed-seed shift register.
module balance_timer_recovery_cmds_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import btr_pkg::*;
    localparam int T = 10;
    logic        sys_clk, srst, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr, balance_select_bits, fault_recover_pulse, d8;
    logic [31:0] pwdata, prdata, seed, q;
    logic [15:0] alarm_status, c16;
    logic        regulator_output_config, regulator_output, e;
    int          err_total, check_count, a, b;
    int          dly[4] = '{0, 1, 4, 16};
    int          vals[5] = '{1, 2, 16, 17, 255};

    balance_timer_recovery_cmds #(.TICK_PERIOD(T)) dut (
        .sys_clk(sys_clk), .srst(srst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .alarm_status(alarm_status),
        .regulator_output_config(regulator_output_config),
        .balance_select_bits(balance_select_bits),
        .regulator_output(regulator_output),
        .fault_recover_pulse(fault_recover_pulse));
    apb_host host (
        .sys_clk(sys_clk), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

    ////////////////////////////////////////////////////////////////////////
    // Helpers
    task automatic check(input string nm, input logic [31:0] seen, exp);
        check_count++;
        if (seen !== exp)
        begin
            $display("wrong value %s: expected %h seen %h", nm, exp, seen);
            err_total++;
        end
    endtask
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Quarter-second units up to 16, whole seconds above
    function automatic int ticks(input int v);
        return (v <= 16) ? v : (v - 12) * 4;
    endfunction
    function automatic logic near(input int s, x);
        return (s >= x - 3) && (s <= x + 3);
    endfunction
    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
        host.xfer(1'b1, ad, d, q, e);
    endtask
    task automatic rd(input logic [7:0] ad);
        host.xfer(1'b0, ad, 32'h0, q, e);
    endtask
    // Count cycles while the regulator stays at one level
    task automatic hold(input logic lvl, output int n);
        n = 0;
        while (regulator_output === lvl && n < 12000)
        begin
            @(posedge sys_clk);
            n++;
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Clock and watchdog
    initial
    begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    initial
    begin
        repeat (60000) @(posedge sys_clk);
        err_total++;
        wrap_up();
    end

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        err_total = 0;
        check_count = 0;
        seed = 32'hCE0F4AA2;
        srst = 1'b1;
        alarm_status = 16'h0;
        regulator_output_config = 1'b0;
        repeat (16) @(posedge sys_clk);
        srst <= 1'b0;
        repeat (3) @(posedge sys_clk);
        check("reg_cfg_off", regulator_output, 1'b0);
        regulator_output_config <= 1'b1;
        for (int i = 0; i < 12; i++)
        begin
            seed = lfsr(seed);
            d8 = (i == 0) ? 8'h3E : (i == 11) ? 8'h00 : seed[7:0] & 8'h3E;
            wr(ADDR_BALANCE, {24'h0, d8});
            rd(ADDR_BALANCE);
            check("balance_rd", q, {24'h0, d8});
            check("balance_out", balance_select_bits, d8);
        end
        $display("test balance finished");
        for (int i = 0; i < 8; i++)
        begin
            seed = lfsr(seed);
            d8 = (i == 0) ? 8'h82 : seed[7:0] & 8'hFE;
            wr(ADDR_RECOVERY, {24'h0, d8});
            @(posedge sys_clk);
            check("recover_on", fault_recover_pulse, d8);
            @(posedge sys_clk);
            check("recover_off", fault_recover_pulse, 8'h00);
        end
        $display("test recovery finished");
        for (int i = 0; i < 3; i++)
        begin
            seed = lfsr(seed);
            c16 = (i == 2) ? 16'h0004 : (seed[15:0] & 16'h0E00) | 16'h0100;
            wr(ADDR_TIMER, {16'h0, c16});
            rd(ADDR_TIMER);
            check("timer_rd", q, {16'h0, c16});
            repeat (6 * T) @(posedge sys_clk);
            check("reg_stays_on", regulator_output, 1'b1);
        end
        for (int dl = 0; dl < 4; dl++)
        begin
            wr(ADDR_TIMER, 32'h0128 | (dl << 9));
            hold(1'b1, a);
            check("sd_delay", near(a, dly[dl] * T), 1'b1);
            wr(ADDR_TIMER, 32'h0);
            hold(1'b0, b);
        end
        $display("test shutdown finished");
        foreach (vals[i])
        begin
            wr(ADDR_TIMER, 32'h0100 | vals[i]);
            hold(1'b1, a);
            hold(1'b0, b);
            check("off_time", near(b, ticks(vals[i]) * T), 1'b1);
            check("restored", regulator_output, 1'b1);
            rd(ADDR_STATUS);
            check("run_clear", q[ST_RUNNING_BIT], 1'b0);
        end
        wr(ADDR_TIMER, 32'h0104);
        repeat (2 * T) @(posedge sys_clk);
        wr(ADDR_TIMER, 32'h0104);
        hold(1'b0, b);
        check("restart", near(b, 4 * T), 1'b1);
        $display("test expiry finished");
        for (int w = 0; w < 2; w++)
        begin
            seed = lfsr(seed);
            wr(ADDR_TIMER, 32'h0108 | (w << 11));
            repeat (2 * T) @(posedge sys_clk);
            alarm_status <= 16'h1 << seed[3:0];
            repeat (8) @(posedge sys_clk);
            check("alarm_wake", regulator_output, w[0]);
            alarm_status <= 16'h0;
            wr(ADDR_TIMER, 32'h0);
            hold(1'b0, b);
        end
        $display("test alarm finished");
        rd(8'h10);
        check("unmapped_err", e, 1'b1);
        wrap_up();
    end
endmodule

bind balance_timer_recovery_cmds btr_checker u_chk (
    .sys_clk(sys_clk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .regulator_output_config(regulator_output_config),
    .balance_select_bits(balance_select_bits),
    .regulator_output(regulator_output),
    .fault_recover_pulse(fault_recover_pulse));
